// ---- design/dcfm_pkg.sv ----
// Shared constants and types for the dual clock FIFO with mailboxes
package dcfm_pkg;
  localparam int          DATA_W_DEF   = 36;
  localparam int          ADDR_W       = 11;
  localparam int          PTR_W        = ADDR_W + 1;
  localparam int          THR_W        = 11;
  localparam int          SER_BITS     = 22;
  localparam int          CNT_W        = 5;
  localparam int          PAR_LOADS    = 2;
  localparam int          IR_DELAY     = 2;
  localparam logic [PTR_W-1:0] DEPTH   = 12'h800;
  localparam logic [THR_W-1:0] PRESET_LO = 11'h008;
  localparam logic [THR_W-1:0] PRESET_HI = 11'h040;
  localparam logic [CNT_W-1:0] SER_LAST  = 5'h16;
  localparam logic [CNT_W-1:0] IR_LAST   = 5'h01;
  localparam logic [1:0]  PAR_DONE     = 2'h2;

  typedef enum logic [1:0] {
    DCFM_SERIAL,
    DCFM_PRESET_HI,
    DCFM_PRESET_LO,
    DCFM_PARALLEL
  } dcfm_mode_t;
endpackage

// ---- design/dcfm_fifo_mailbox.sv ----
// Dual port FIFO with mailboxes, both ports sampled on one system clock
`timescale 1ns/1ns

// Functional notes
// [RULE1] Preset selects 8 or 64, ready after two
// [RULE2] Parallel mode: first two writes load thresholds
// [RULE3] Thresholds on data bits 10..0, 1..2044
// [RULE4] Serial mode shifts one bit per strobed edge
// [RULE5] Twenty-two bits, full MSB first, empty LSB last
// [RULE6] Serial: ready only after last bit loaded
// [RULE7] Side A drives mailbox only when selected reading
// [RULE8] Side A FIFO write needs full qualification
// [RULE9] Side A mail write fills A-to-B mailbox
// [RULE10] Side A mail read raises B-to-A flag
// [RULE11] Side B direction input has inverted polarity
// [RULE12] Side B drives mailbox or output register
// [RULE13] Side B FIFO read needs full qualification
// [RULE14] Side B mail write fills B-to-A mailbox
// [RULE15] Side B mail read raises A-to-B flag
// [RULE16] Empty output register loads automatically when ready
// [RULE17] Ready output register changes only on read
// [RULE18] Status flags pass two stages per side
// [RULE19] Load method decoded at reset release
// [RULE20] Reset clears pointers and sets flags
// [RULE21] Mail flag low on write, high on read
// [RULE22] 2048 by 36 storage, 11-bit thresholds
// [RULE23] Writes when full, reads when empty ignored
module dcfm_fifo_mailbox
  import dcfm_pkg::*;
#(
  parameter int DATA_W = dcfm_pkg::DATA_W_DEF
)(
  // System
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Device pins, common
  input  wire logic                          deviceResetN,
  input  wire logic                          select0SerialData,
  input  wire logic                          select1SerialStrobeN,
  // Side A pins
  input  wire logic                          sideAClock,
  input  wire logic                          sideASelectN,
  input  wire logic                          sideAWriteNotRead,
  input  wire logic                          sideAGate,
  input  wire logic                          sideAMailSelect,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] sideABusIn,
  output logic      [dcfm_pkg::DATA_W_DEF-1:0] sideABusOut,
  output logic                               sideABusOe,
  // Side B pins
  input  wire logic                          sideBClock,
  input  wire logic                          sideBSelectN,
  input  wire logic                          sideBReadNotWrite,
  input  wire logic                          sideBGate,
  input  wire logic                          sideBMailSelect,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] sideBBusIn,
  output logic      [dcfm_pkg::DATA_W_DEF-1:0] sideBBusOut,
  output logic                               sideBBusOe,
  // Status flags
  output logic                               inputReady,
  output logic                               outputReady,
  output logic                               almostEmptyN,
  output logic                               almostFullN,
  output logic                               aToBMailFlagN,
  output logic                               bToAMailFlagN
);
  import dcfm_pkg::*;

  // The pins carry the documented width, so the parameter must match it
  if (DATA_W != DATA_W_DEF)
  begin : gBadWidth
    $error("DATA_W must equal the pin width");
  end

  localparam int IN_W = 13 + 2 * DATA_W_DEF;
  localparam int DW   = DATA_W_DEF;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; every pin shares the same delay so data lines up
  logic [IN_W-1:0] sync1_ff;
  logic [IN_W-1:0] sync2_ff;
  logic            aClkPrev_ff;
  logic            bClkPrev_ff;
  logic            rstNPrev_ff;
  logic            aClkS, bClkS, rstNS, sel0S, sel1S;
  logic            aSelNS, aWnrS, aGateS, aMbS;
  logic            bSelNS, bRnwS, bGateS, bMbS;
  logic [DW-1:0]   aBusS;
  logic [DW-1:0]   bBusS;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= {sideAClock, sideBClock, deviceResetN, select0SerialData,
                   select1SerialStrobeN, sideASelectN, sideAWriteNotRead,
                   sideAGate, sideAMailSelect, sideBSelectN,
                   sideBReadNotWrite, sideBGate, sideBMailSelect,
                   sideABusIn, sideBBusIn};
      sync2_ff <= sync1_ff;
    end
  end

  assign {aClkS, bClkS, rstNS, sel0S, sel1S, aSelNS, aWnrS, aGateS, aMbS,
          bSelNS, bRnwS, bGateS, bMbS, aBusS, bBusS} = sync2_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      aClkPrev_ff <= 1'b0;
      bClkPrev_ff <= 1'b0;
      rstNPrev_ff <= 1'b0;
    end
    else
    begin
      aClkPrev_ff <= aClkS;
      bClkPrev_ff <= bClkS;
      rstNPrev_ff <= rstNS;
    end
  end

  // Port clocks become one-cycle enables on mclk
  logic aTick, bTick, resetting, release_;
  assign aTick     = aClkS & ~aClkPrev_ff;
  assign bTick     = bClkS & ~bClkPrev_ff;
  assign resetting = ~rstNS;
  assign release_  = rstNS & ~rstNPrev_ff;

  //////////////////////////////////////////////////////////////////////////
  // Port decode; side B direction is the inverse of side A
  logic aPortOn, bPortOn, bWrite;
  logic fifoWrA, mailWrA, mailRdA;
  logic fifoRdB, mailWrB, mailRdB;
  logic parDone;
  dcfm_mode_t mode_ff;
  logic [1:0] parCnt_ff;

  assign aPortOn = aTick & ~aSelNS & aGateS & ~resetting;
  assign bPortOn = bTick & ~bSelNS & bGateS & ~resetting;
  assign bWrite  = ~bRnwS;                                        // RULE11
  assign parDone = (mode_ff != DCFM_PARALLEL) || (parCnt_ff == PAR_DONE);
  assign fifoWrA = aPortOn & ~aMbS & aWnrS & inputReady & parDone;// RULE8
  assign mailWrA = aPortOn & aMbS & aWnrS;                        // RULE9
  assign mailRdA = aPortOn & aMbS & ~aWnrS;                       // RULE10
  assign fifoRdB = bPortOn & ~bMbS & ~bWrite & outputReady;       // RULE13
  assign mailWrB = bPortOn & bMbS & bWrite;                       // RULE14
  assign mailRdB = bPortOn & bMbS & ~bWrite;                      // RULE15

  //////////////////////////////////////////////////////////////////////////
  // Threshold setup: method latched at release, then preset/parallel/serial
  logic [THR_W-1:0] fullThr_ff;
  logic [THR_W-1:0] emptyThr_ff;
  logic [CNT_W-1:0] cfgCnt_ff;
  logic             irAllow_ff;
  logic             nxtIrAllow;

  always_comb
  begin
    nxtIrAllow = irAllow_ff;
    if (!irAllow_ff && aTick && !resetting && !release_)
    begin
      case (mode_ff)
        DCFM_SERIAL:
          nxtIrAllow = (cfgCnt_ff == SER_LAST);                   // RULE6
        default:
          nxtIrAllow = (cfgCnt_ff == IR_LAST);                    // RULE1
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      mode_ff     <= DCFM_SERIAL;
      fullThr_ff  <= PRESET_LO;
      emptyThr_ff <= PRESET_LO;
      cfgCnt_ff   <= '0;
      parCnt_ff   <= '0;
      irAllow_ff  <= 1'b0;
    end
    else if (release_)
    begin
      cfgCnt_ff  <= '0;
      parCnt_ff  <= '0;
      irAllow_ff <= 1'b0;
      case ({sel1S, sel0S})                                       // RULE19
        2'b11:   mode_ff <= DCFM_SERIAL;
        2'b10:
        begin
          mode_ff     <= DCFM_PRESET_HI;
          fullThr_ff  <= PRESET_HI;                               // RULE1
          emptyThr_ff <= PRESET_HI;
        end
        2'b01:
        begin
          mode_ff     <= DCFM_PRESET_LO;
          fullThr_ff  <= PRESET_LO;                               // RULE1
          emptyThr_ff <= PRESET_LO;
        end
        default: mode_ff <= DCFM_PARALLEL;
      endcase
    end
    else
    begin
      irAllow_ff <= nxtIrAllow;
      if (!irAllow_ff && aTick)
      begin
        if (mode_ff != DCFM_SERIAL)
          cfgCnt_ff <= cfgCnt_ff + 5'h01;
        else if (!sel1S && cfgCnt_ff != SER_LAST)
        begin
          // Full threshold MSB enters first, empty LSB last
          {fullThr_ff, emptyThr_ff} <= {fullThr_ff[THR_W-2:0],
                                        emptyThr_ff, sel0S};      // RULE4 RULE5
          cfgCnt_ff <= cfgCnt_ff + 5'h01;
        end
      end
      // Writes that load thresholds never reach memory; range is the writer's
      if (aPortOn && !aMbS && aWnrS && inputReady && !parDone)    // RULE2 RULE3
      begin
        if (parCnt_ff == 2'h0)
          fullThr_ff <= aBusS[THR_W-1:0];
        else
          emptyThr_ff <= aBusS[THR_W-1:0];
        parCnt_ff <= parCnt_ff + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage and pointers; one spare pointer bit tells full from empty
  logic [DW-1:0]    mem [0:(1<<ADDR_W)-1];                         // RULE22
  logic [PTR_W-1:0] wrPtr_ff;
  logic [PTR_W-1:0] rdPtr_ff;
  logic [PTR_W-1:0] rdPtrA1_ff, rdPtrA2_ff;
  logic [PTR_W-1:0] wrPtrB1_ff, wrPtrB2_ff;
  logic [DW-1:0]    outReg_ff;
  logic             popB;

  always_ff @(posedge mclk)
  begin
    if (fifoWrA)
      mem[wrPtr_ff[ADDR_W-1:0]] <= aBusS;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
      wrPtr_ff <= '0;                                             // RULE20
    else if (fifoWrA)
      wrPtr_ff <= wrPtr_ff + 12'h001;                             // RULE23
  end

  // Pointer copies lag two port edges; stale values only err safe
  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      rdPtrA1_ff <= '0;
      rdPtrA2_ff <= '0;
      wrPtrB1_ff <= '0;
      wrPtrB2_ff <= '0;
    end
    else
    begin
      if (aTick)
      begin
        rdPtrA1_ff <= rdPtr_ff;                                   // RULE18
        rdPtrA2_ff <= rdPtrA1_ff;
      end
      if (bTick)
      begin
        wrPtrB1_ff <= wrPtr_ff;                                   // RULE18
        wrPtrB2_ff <= wrPtrB1_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output register and output-ready on side B
  logic avail;
  assign avail = (wrPtrB2_ff != rdPtr_ff);
  assign popB  = bTick & ~resetting & avail & (~outputReady | fifoRdB);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      rdPtr_ff    <= '0;                                          // RULE20
      outputReady <= 1'b0;
      outReg_ff   <= '0;
    end
    else if (bTick)
    begin
      if (popB)                                                   // RULE16 RULE17
      begin
        outReg_ff   <= mem[rdPtr_ff[ADDR_W-1:0]];
        rdPtr_ff    <= rdPtr_ff + 12'h001;
        outputReady <= 1'b1;
      end
      else if (fifoRdB)
        outputReady <= 1'b0;                                      // RULE23
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Side A flags
  logic [PTR_W-1:0] nxtWr;
  logic [PTR_W-1:0] usedA;
  assign nxtWr = fifoWrA ? wrPtr_ff + 12'h001 : wrPtr_ff;
  assign usedA = nxtWr - rdPtrA2_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      inputReady  <= 1'b0;                                        // RULE20
      almostFullN <= 1'b1;
    end
    else if (aTick)
    begin
      inputReady  <= nxtIrAllow && (usedA != DEPTH);
      almostFullN <= ({1'b0, usedA} + {2'b00, fullThr_ff})
                     < {1'b0, DEPTH};
    end
  end

  // Side B almost-empty counts words still in memory only
  logic [PTR_W-1:0] usedB;
  assign usedB = wrPtrB2_ff - rdPtr_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
      almostEmptyN <= 1'b0;                                       // RULE20
    else if (bTick)
      almostEmptyN <= usedB > {1'b0, emptyThr_ff};
  end

  //////////////////////////////////////////////////////////////////////////
  // Mailboxes; a write beats a same-cycle read so no mail is lost
  logic [DW-1:0] mailAB_ff;
  logic [DW-1:0] mailBA_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      mailAB_ff     <= '0;
      aToBMailFlagN <= 1'b1;                                      // RULE20
    end
    else if (mailWrA)
    begin
      mailAB_ff     <= aBusS;
      aToBMailFlagN <= 1'b0;                                      // RULE21
    end
    else if (mailRdB)
      aToBMailFlagN <= 1'b1;                                      // RULE15
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || resetting)
    begin
      mailBA_ff     <= '0;
      bToAMailFlagN <= 1'b1;                                      // RULE20
    end
    else if (mailWrB)
    begin
      mailBA_ff     <= bBusS;
      bToAMailFlagN <= 1'b0;                                      // RULE21
    end
    else if (mailRdA)
      bToAMailFlagN <= 1'b1;                                      // RULE10
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus drivers
  assign sideABusOe  = ~aSelNS & ~aWnrS;                          // RULE7
  assign sideABusOut = mailBA_ff;
  assign sideBBusOe  = ~bSelNS & bRnwS;                           // RULE12

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sideBBusOut <= '0;
    else
      sideBBusOut <= bMbS ? mailAB_ff : outReg_ff;                // RULE12
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_reset_flags: assert property (resetting |=> !inputReady && almostFullN
      && aToBMailFlagN && bToAMailFlagN && wrPtr_ff == '0) // RULE20
    else $error("reset did not force flags and pointer");
  chk_a_drive_cond: assert property (sideABusOe |-> !aSelNS && !aWnrS) // RULE7
    else $error("side A driven while not reading");
  chk_fifo_write: assert property (fifoWrA |=>
      wrPtr_ff == $past(wrPtr_ff) + 12'h001) // RULE8
    else $error("accepted write did not advance pointer");
  chk_full_ignored: assert property (aTick && !inputReady && !resetting
      |=> wrPtr_ff == $past(wrPtr_ff)) // RULE23
    else $error("write taken while not ready");
  chk_mail_write: assert property (mailWrA |=> !aToBMailFlagN
      && mailAB_ff == $past(aBusS)) // RULE21
    else $error("mail write did not land or flag");
  chk_mail_read: assert property (mailRdB && !mailWrA |=> aToBMailFlagN) // RULE15
    else $error("mail read did not raise flag");
  chk_or_auto_load: assert property (bTick && !outputReady && avail
      && !resetting |=> outputReady && rdPtr_ff == $past(rdPtr_ff)
      + 12'h001) // RULE16
    else $error("empty output register not refilled");
  chk_or_hold: assert property (outputReady && !fifoRdB && !resetting
      |=> outReg_ff == $past(outReg_ff)) // RULE17
    else $error("output register changed without read");
  chk_serial_ready: assert property (mode_ff == DCFM_SERIAL
      && cfgCnt_ff != SER_LAST && !irAllow_ff |-> !inputReady) // RULE6
    else $error("ready raised before serial load done");
endmodule

// ---- tb/dcfm_port_master.sv ----
// Far-side model: free-running port clocks and resolved data buses
`timescale 1ns/1ns
module dcfm_port_master
(
  // System
  input  wire logic                            mclk,
  // Side A master
  input  wire logic                            aDrvEn,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] aDrv,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] aOut,
  input  wire logic                            aOe,
  output logic                                 aClk,
  output logic      [dcfm_pkg::DATA_W_DEF-1:0] aBus,
  // Side B master
  input  wire logic                            bDrvEn,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] bDrv,
  input  wire logic [dcfm_pkg::DATA_W_DEF-1:0] bOut,
  input  wire logic                            bOe,
  output logic                                 bClk,
  output logic      [dcfm_pkg::DATA_W_DEF-1:0] bBus
);
  import dcfm_pkg::*;
  logic [2:0]            aCnt_ff = 3'h0;
  logic [3:0]            bCnt_ff = 4'h0;
  logic [DATA_W_DEF-1:0] aLast_ff = '0;
  logic [DATA_W_DEF-1:0] bLast_ff = '0;
  //////////////////////////////////////////////////////////////////////////
  // Clocks never stop, so reset always sees at least six rising edges per side
  always_ff @(posedge mclk) aCnt_ff <= aCnt_ff + 3'h1;
  always_ff @(posedge mclk) bCnt_ff <= (bCnt_ff == 4'h9) ? 4'h0 : bCnt_ff + 4'h1;
  assign aClk = aCnt_ff[2];
  assign bClk = (bCnt_ff >= 4'h5);
  //////////////////////////////////////////////////////////////////////////
  // Undriven bus shows the inverse of its last level, never stale data
  always_ff @(posedge mclk) aLast_ff <= aBus;
  always_ff @(posedge mclk) bLast_ff <= bBus;
  assign aBus = aOe ? aOut : (aDrvEn ? aDrv : ~aLast_ff);
  assign bBus = bOe ? bOut : (bDrvEn ? bDrv : ~bLast_ff);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the dual clock FIFO with mailboxes
`timescale 1ns/1ns
module testbench;
  import dcfm_pkg::*;
  // ctl = {sideB, selectN, direction pin, gate, mail}; fl = {oe, aToB, bToA}
  typedef struct packed {
    logic [4:0]  ctl;
    logic [35:0] data;
    logic [2:0]  fl;
    logic [35:0] bus;
  } dcfm_row_t;
  localparam logic [35:0] M1 = 36'h1_2345_6789;
  localparam logic [35:0] M2 = 36'h9_8765_4321;
  localparam logic [35:0] D0 = 36'h0_a5a5_0000;
  // Serial pattern: full threshold 2044 first, then empty threshold 1
  localparam logic [21:0] SERPAT = {11'h7fc, 11'h001};
  localparam dcfm_row_t ROWS [8] = '{
    '{5'h07, M1, 3'h1, 36'h0}, '{5'h15, 36'h0, 3'h5, M1},
    '{5'h1f, 36'h0, 3'h1, 36'h0}, '{5'h17, 36'h0, 3'h7, M1},
    '{5'h13, M2, 3'h2, 36'h0}, '{5'h02, 36'h0, 3'h6, M2},
    '{5'h0f, M1, 3'h2, 36'h0}, '{5'h03, 36'h0, 3'h7, M2}};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        deviceResetN = 1'b0;
  logic        sel0 = 1'b0;
  logic        sel1 = 1'b1;
  logic        aCsN = 1'b1, aDir = 1'b0, aGate = 1'b0, aMb = 1'b0;
  logic        bCsN = 1'b1, bDir = 1'b1, bGate = 1'b0, bMb = 1'b0;
  logic [35:0] aDrv = '0, bDrv = '0, aBus, bBus, aOut, bOut, seenBus;
  logic        aClk, bClk, aOe, bOe, seenOe, inputReady, outputReady;
  logic        almostEmptyN, almostFullN, aToBMailFlagN, bToAMailFlagN;
  int          nFail = 0;
  int          comparisons = 0;
  always #50 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  dcfm_port_master u_master (.mclk(mclk), .aDrvEn(!aCsN && aDir), .aDrv(aDrv),
    .aOut(aOut), .aOe(aOe), .aClk(aClk), .aBus(aBus),
    .bDrvEn(!bCsN && !bDir), .bDrv(bDrv), .bOut(bOut), .bOe(bOe),
    .bClk(bClk), .bBus(bBus));
  dcfm_fifo_mailbox u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .deviceResetN(deviceResetN), .select0SerialData(sel0),
    .select1SerialStrobeN(sel1), .sideAClock(aClk), .sideASelectN(aCsN),
    .sideAWriteNotRead(aDir), .sideAGate(aGate), .sideAMailSelect(aMb),
    .sideABusIn(aBus), .sideABusOut(aOut), .sideABusOe(aOe),
    .sideBClock(bClk), .sideBSelectN(bCsN), .sideBReadNotWrite(bDir),
    .sideBGate(bGate), .sideBMailSelect(bMb), .sideBBusIn(bBus),
    .sideBBusOut(bOut), .sideBBusOe(bOe), .inputReady(inputReady),
    .outputReady(outputReady), .almostEmptyN(almostEmptyN),
    .almostFullN(almostFullN), .aToBMailFlagN(aToBMailFlagN),
    .bToAMailFlagN(bToAMailFlagN));
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, nFail);
    if (nFail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      nFail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkW(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
    comparisons++;
    if (g !== e)
    begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for a level; a hang is cut short here
  task automatic waitLvl(input logic [1:0] which, input logic lvl);
    logic v;
    for (int n = 0; n < 400; n++)
    begin
      v = which[1] ? (which[0] ? outputReady : inputReady)
                   : (which[0] ? bClk : aClk);
      if (v === lvl)
        return;
      @(posedge mclk);
    end
    chk1("timeout", 1'b1, 1'b0);
    tally_and_finish();
  endtask
  // One port transfer: set up in the low half, hold past the rising edge
  task automatic portOp(input logic [4:0] c, input logic [35:0] d);
    waitLvl({1'b0, c[4]}, 1'b1);
    waitLvl({1'b0, c[4]}, 1'b0);
    if (c[4])
      {bCsN, bDir, bGate, bMb} <= c[3:0];
    else
      {aCsN, aDir, aGate, aMb} <= c[3:0];
    aDrv <= d;
    bDrv <= d;
    waitLvl({1'b0, c[4]}, 1'b1);
    repeat (3) @(posedge mclk);
    seenOe = c[4] ? bOe : aOe;
    seenBus = c[4] ? bBus : aBus;
    aCsN <= 1'b1;
    aGate <= 1'b0;
    bCsN <= 1'b1;
    bGate <= 1'b0;
  endtask
  task automatic devReset(input logic s1, input logic s0);
    deviceResetN <= 1'b0;
    sel1 <= s1;
    sel0 <= s0;
    repeat (60) @(posedge mclk);
    chk1("inputReady", 1'b0, inputReady);
    chk1("almostEmptyN", 1'b0, almostEmptyN);
    chk1("almostFullN", 1'b1, almostFullN);
    chk1("aToBFlagN", 1'b1, aToBMailFlagN);
    chk1("bToAFlagN", 1'b1, bToAMailFlagN);
    deviceResetN <= 1'b1;
    repeat (6) @(posedge mclk);
    chk1("inputReady", 1'b0, inputReady);
    sel1 <= 1'b1;
  endtask
  // Five data words after thresholds full 2044, empty 1
  task automatic fillCheck();
    for (int i = 0; i < 5; i++)
      portOp(5'h06, D0 + 36'(i));
    repeat (60) @(posedge mclk);
    chk1("almostFullN", 1'b0, almostFullN);
    chk1("almostEmptyN", 1'b1, almostEmptyN);
    chkW("outReg", D0, bOut);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    devReset(1'b1, 1'b0);
    waitLvl(2'h2, 1'b1);
    foreach (ROWS[i])
    begin
      portOp(ROWS[i].ctl, ROWS[i].data);
      chk1("busOe", ROWS[i].fl[2], seenOe);
      if (ROWS[i].fl[2])
        chkW("bus", ROWS[i].bus, seenBus);
      repeat (3) @(posedge mclk);
      chk1("aToBFlagN", ROWS[i].fl[1], aToBMailFlagN);
      chk1("bToAFlagN", ROWS[i].fl[0], bToAMailFlagN);
    end
    $display("test mailbox done");
    devReset(1'b0, 1'b1);
    waitLvl(2'h2, 1'b1);
    for (int i = 0; i < 10; i++)
      portOp(5'h06, D0 + 36'(i));
    waitLvl(2'h3, 1'b1);
    repeat (60) @(posedge mclk);
    chk1("almostEmptyN", 1'b1, almostEmptyN);
    portOp(5'h14, 36'h0);
    chkW("outReg", D0, seenBus);
    for (int i = 1; i < 11; i++)
    begin
      portOp(5'h16, 36'h0);
      repeat (3) @(posedge mclk);
      chkW("outReg", D0 + 36'((i > 9) ? 9 : i), bOut);
    end
    chk1("outputReady", 1'b0, outputReady);
    $display("test fifo path done");
    devReset(1'b0, 1'b0);
    waitLvl(2'h2, 1'b1);
    portOp(5'h06, 36'h0_0000_07fc);
    portOp(5'h06, 36'h0_0000_0001);
    fillCheck();
    $display("test parallel load done");
    devReset(1'b1, 1'b1);
    portOp(5'h06, 36'hb_adba_dbad);
    for (int i = 21; i >= 0; i--)
    begin
      waitLvl(2'h0, 1'b1);
      waitLvl(2'h0, 1'b0);
      sel0 <= SERPAT[i];
      sel1 <= 1'b0;
      waitLvl(2'h0, 1'b1);
      repeat (3) @(posedge mclk);
      if (i == 1)
        chk1("inputReady", 1'b0, inputReady);
    end
    sel1 <= 1'b1;
    waitLvl(2'h2, 1'b1);
    fillCheck();
    $display("test serial load done");
    tally_and_finish();
  end
endmodule
